// file: hdl/serial_pkg.sv
/*
 Shared constants and types of the serial port with baud selection.
 Assumes an 8-bit I/O space host bus on the core clock.
*/
package serial_pkg;
    // I/O addresses
    localparam logic [7:0] ADDR_BAUD = 8'hDE;
    localparam logic [7:0] ADDR_DATA = 8'hEC;
    localparam logic [7:0] ADDR_CTRL = 8'hED;
    localparam logic [7:0] ADDR_SYNC = 8'hEE;
    // Reset values
    localparam logic [7:0]  CTRL_RST   = 8'h00;
    localparam logic [7:0]  SYNC_RST   = 8'h16;
    localparam logic [15:0] FACTOR_RST = 16'h0000;
    // Status bit positions
    localparam int ST_TXRDY = 0;
    localparam int ST_RXRDY = 1;
    localparam int ST_LOCK  = 2;
    localparam int ST_OVR   = 3;
    // Oversampling counts
    localparam logic [7:0] OS_SYNC = 8'h01;
    localparam logic [7:0] OS_16   = 8'h10;
    localparam logic [7:0] OS_64   = 8'h40;
    localparam logic [2:0] LEN_MIN = 3'h4;
    localparam int         BUF_DEPTH = 2;

    // Control byte layout, bit 7 down to bit 0
    typedef struct packed {
        logic       ext_sync;  // External character sync
        logic       brk;       // Force break on line
        logic       div64;     // Async bit = 64 clocks
        logic [1:0] stop;      // 0: 1, 1: 1.5, 2/3: 2 stop bits
        logic [1:0] len;       // Character length minus five
        logic       sync;      // Synchronous mode
    } cfg_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] data;
    } io_req_t;

    typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} tx_state_t;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP, RX_HUNT} rx_state_t;
endpackage

// file: hdl/two_entry_buf.sv
/*
 Two-entry buffer with valid/ready on both sides.
 Assumes one clock, asynchronous active-low reset, clock enable.
*/
`timescale 1ns/10ps
`default_nettype none
module two_entry_buf #(
    parameter int W     = 8,
    parameter int DEPTH = 2
) (
    input  wire logic         clk,       // Core clock
    input  wire logic         rst_n,     // Reset, active low
    input  wire logic         ce,        // Clock enable
    input  wire logic         in_valid,  // Write offered
    output logic              in_ready,  // Space free
    input  wire logic [W-1:0] in_data,   // Write word
    output logic              out_valid, // Word held
    input  wire logic         out_ready, // Drain accepts
    output logic [W-1:0]      out_data   // Oldest word
);
    // Structure serves exactly two entries
    if (DEPTH != 2) begin : g_chk
        $error("two_entry_buf supports DEPTH of 2 only");
    end

    logic [W-1:0] mem_ff [DEPTH];
    logic         wp_ff;
    logic         rp_ff;
    logic [1:0]   cnt_ff;

    // Handshakes
    wire push = ce && in_valid && in_ready;
    wire pop  = ce && out_valid && out_ready;
    assign in_ready  = cnt_ff != 2'h2;
    assign out_valid = cnt_ff != 2'h0;
    assign out_data  = mem_ff[rp_ff];

    // Storage
    always_ff @(posedge clk) begin
        if (push) begin
            mem_ff[wp_ff] <= in_data;
        end
    end

    // Pointers and fill count
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_ff  <= 1'b0;
            rp_ff  <= 1'b0;
            cnt_ff <= 2'h0;
        end else begin
            if (push) wp_ff <= ~wp_ff;
            if (pop)  rp_ff <= ~rp_ff;
            cnt_ff <= cnt_ff + 2'(push) - 2'(pop);
        end
    end
endmodule
`default_nettype wire

// file: hdl/serial_port.sv
/*
 Serial port with software-selected baud clock, sync and async framing.
 Assumes host I/O requests on core_clk; rxd and ext sync come from pins.
*/
`timescale 1ns/10ps
`default_nettype none
module serial_port (
    input  wire logic              core_clk,   // 250 MHz core clock
    input  wire logic              rst_n,      // Async reset, active low
    input  wire logic              ce,         // Clock enable
    input  wire serial_pkg::io_req_t io_req,   // Host I/O request
    output logic [7:0]             io_rdata,   // Read data, next cycle
    input  wire logic              rxd,        // Serial receive pin
    input  wire logic              sync_in,    // External sync detect pin
    output logic                   txd,        // Serial transmit pin
    output logic                   rx_irq,     // Character waiting
    output logic                   tx_irq      // Transmit buffer has room
);
    import serial_pkg::*;

    // Character alignment of an LSB-first shift register
    function automatic logic [7:0] align(input logic [7:0] v, input logic [1:0] len);
        return v >> (2'h3 - len);
    endfunction

    logic       rs1_ff, rst_i;
    logic       rxm_ff, rxs_ff, snm_ff, sns_ff;
    cfg_t       cfg_ff;
    logic [7:0] sync_ff, lo_ff, rdata_ff, rxbuf_ff;
    logic       hi_sel_ff, rxrdy_ff, ovr_ff, txd_ff, rxirq_ff, txirq_ff;
    logic [15:0] factor_ff, baud_cnt_ff;
    tx_state_t  tx_st_ff;
    rx_state_t  rx_st_ff;
    logic [7:0] tx_sh_ff, rx_sh_ff, tx_cnt_ff, rx_cnt_ff;
    logic [2:0] tx_idx_ff, rx_idx_ff;

    // Reset release through two flip-flops
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rs1_ff <= 1'b0;
            rst_i  <= 1'b0;
        end else begin
            rs1_ff <= 1'b1;
            rst_i  <= rs1_ff;
        end
    end

    // Pin synchronisers
    always_ff @(posedge core_clk or negedge rst_i) begin
        if (!rst_i) begin
            {rxm_ff, rxs_ff, snm_ff, sns_ff} <= 4'hC;  // Line idle high, sync low
        end else if (ce) begin
            rxm_ff <= rxd;
            rxs_ff <= rxm_ff;
            snm_ff <= sync_in;
            sns_ff <= snm_ff;
        end
    end

    // Address decode
    wire wr_baud = io_req.wr && io_req.addr == ADDR_BAUD;
    wire wr_data = io_req.wr && io_req.addr == ADDR_DATA;
    wire wr_ctrl = io_req.wr && io_req.addr == ADDR_CTRL;
    wire wr_sync = io_req.wr && io_req.addr == ADDR_SYNC;
    wire rd_data = io_req.rd && io_req.addr == ADDR_DATA;
    wire rd_ctrl = io_req.rd && io_req.addr == ADDR_CTRL;

    // Baud clock from the programmed factor
    wire        baud_on   = factor_ff != 16'h0000;
    wire        baud_tick = baud_on && baud_cnt_ff == 16'h0000;
    wire [15:0] nxt_baud  = !baud_on ? 16'h0000 :
                            baud_tick ? factor_ff - 16'h0001 : baud_cnt_ff - 16'h0001;

    // Bit timing: one baud clock per bit in sync, 16 or 64 in async
    wire [7:0] os_len   = cfg_ff.sync ? OS_SYNC : (cfg_ff.div64 ? OS_64 : OS_16);
    wire [7:0] half     = os_len >> 1;
    wire [7:0] stop_len = cfg_ff.stop == 2'h0 ? os_len :
                          cfg_ff.stop == 2'h1 ? os_len + half : os_len << 1;
    wire [2:0] last_idx = {1'b0, cfg_ff.len} + LEN_MIN;

    // Transmit buffer
    logic       tb_in_rdy, tb_out_vld, tb_pop;
    logic [7:0] tb_out;
    two_entry_buf #(.W(8), .DEPTH(BUF_DEPTH)) u_txbuf (
        .clk       (core_clk),
        .rst_n     (rst_i),
        .ce        (ce),
        .in_valid  (wr_data),
        .in_ready  (tb_in_rdy),
        .in_data   (io_req.data),
        .out_valid (tb_out_vld),
        .out_ready (tb_pop),
        .out_data  (tb_out)
    );

    // Transmit bit boundaries and line level
    wire [7:0] tx_tgt  = (tx_st_ff == TX_STOP) ? stop_len - 8'h01 : os_len - 8'h01;
    wire       tx_end  = baud_tick && tx_cnt_ff == tx_tgt;
    wire       tx_last = tx_idx_ff == last_idx;
    wire       tx_wrap = tx_st_ff == TX_DATA && tx_end && tx_last && cfg_ff.sync;
    assign tb_pop = tx_st_ff == TX_IDLE || tx_wrap;
    wire       nxt_txd = cfg_ff.brk ? 1'b0 :
                         tx_st_ff == TX_START ? 1'b0 :
                         tx_st_ff == TX_DATA ? tx_sh_ff[0] : 1'b1;

    // Receive bit boundaries and completed character
    wire [7:0] rx_tgt  = (rx_st_ff == RX_START) ? half - 8'h01 : os_len - 8'h01;
    wire       rx_end  = baud_tick && rx_cnt_ff == rx_tgt;
    wire [7:0] rx_nsh  = {rxs_ff, rx_sh_ff[7:1]};
    wire       rx_done = rx_st_ff == RX_DATA && rx_end && rx_idx_ff == last_idx;
    wire       sync_hit = cfg_ff.ext_sync ? sns_ff :
                          align(rx_nsh, cfg_ff.len) == align(sync_ff, cfg_ff.len);
    wire [7:0] status  = {4'h0, ovr_ff, cfg_ff.sync && rx_st_ff == RX_DATA, rxrdy_ff, tb_in_rdy};
    wire [7:0] nxt_rd  = rd_data ? rxbuf_ff : (rd_ctrl ? status : 8'h00);

    // Host registers, factor assembly and read data
    always_ff @(posedge core_clk or negedge rst_i) begin
        if (!rst_i) begin
            cfg_ff    <= cfg_t'(CTRL_RST);
            sync_ff   <= SYNC_RST;
            factor_ff <= FACTOR_RST;
            lo_ff     <= 8'h00;
            hi_sel_ff <= 1'b0;
            rdata_ff  <= 8'h00;
        end else if (ce) begin
            if (wr_ctrl) cfg_ff <= cfg_t'(io_req.data);
            if (wr_sync) sync_ff <= io_req.data;
            if (wr_baud) hi_sel_ff <= ~hi_sel_ff;
            if (wr_baud && !hi_sel_ff) lo_ff <= io_req.data;
            if (wr_baud && hi_sel_ff) factor_ff <= {io_req.data, lo_ff};
            rdata_ff <= nxt_rd;
        end
    end

    // Baud counter
    always_ff @(posedge core_clk or negedge rst_i) begin
        if (!rst_i) baud_cnt_ff <= 16'h0000;
        else if (ce) baud_cnt_ff <= nxt_baud;
    end

    // Transmitter
    always_ff @(posedge core_clk or negedge rst_i) begin
        if (!rst_i) begin
            tx_st_ff  <= TX_IDLE;
            tx_sh_ff  <= 8'h00;
            tx_cnt_ff <= 8'h00;
            tx_idx_ff <= 3'h0;
            txd_ff    <= 1'b1;
        end else if (ce) begin
            txd_ff <= nxt_txd;
            if (tx_st_ff == TX_IDLE) tx_cnt_ff <= 8'h00;
            else if (baud_tick) tx_cnt_ff <= tx_end ? 8'h00 : tx_cnt_ff + 8'h01;
            unique case (tx_st_ff)
                TX_IDLE: begin
                    tx_idx_ff <= 3'h0;
                    if (cfg_ff.sync) begin
                        tx_sh_ff <= tb_out_vld ? tb_out : sync_ff;
                        tx_st_ff <= TX_DATA;
                    end else if (tb_out_vld) begin
                        tx_sh_ff <= tb_out;
                        tx_st_ff <= TX_START;
                    end
                end
                TX_START: if (tx_end) tx_st_ff <= TX_DATA;
                TX_DATA: if (tx_end) begin
                    tx_sh_ff  <= tx_sh_ff >> 1;
                    tx_idx_ff <= tx_idx_ff + 3'h1;
                    if (tx_last) tx_idx_ff <= 3'h0;
                    if (tx_wrap) tx_sh_ff <= tb_out_vld ? tb_out : sync_ff;
                    else if (tx_last) tx_st_ff <= TX_STOP;
                end
                TX_STOP: if (tx_end) tx_st_ff <= TX_IDLE;
            endcase
        end
    end

    // Receiver
    always_ff @(posedge core_clk or negedge rst_i) begin
        if (!rst_i) begin
            rx_st_ff  <= RX_IDLE;
            rx_sh_ff  <= 8'h00;
            rx_cnt_ff <= 8'h00;
            rx_idx_ff <= 3'h0;
        end else if (ce) begin
            if (rx_st_ff == RX_IDLE || rx_st_ff == RX_HUNT) rx_cnt_ff <= 8'h00;
            else if (baud_tick) rx_cnt_ff <= rx_end ? 8'h00 : rx_cnt_ff + 8'h01;
            unique case (rx_st_ff)
                RX_IDLE: begin
                    rx_idx_ff <= 3'h0;
                    if (cfg_ff.sync) rx_st_ff <= RX_HUNT;
                    else if (baud_tick && !rxs_ff) rx_st_ff <= RX_START;
                end
                RX_START: if (rx_end) rx_st_ff <= rxs_ff ? RX_IDLE : RX_DATA;
                RX_DATA: if (rx_end) begin
                    rx_sh_ff  <= rx_nsh;
                    rx_idx_ff <= rx_done ? 3'h0 : rx_idx_ff + 3'h1;
                    if (rx_done && !cfg_ff.sync) rx_st_ff <= RX_STOP;
                end
                RX_STOP: if (rx_end) rx_st_ff <= RX_IDLE;
                RX_HUNT: begin
                    if (!cfg_ff.sync) rx_st_ff <= RX_IDLE;
                    else if (baud_tick) begin
                        rx_sh_ff <= rx_nsh;
                        if (sync_hit) rx_st_ff <= RX_DATA;
                    end
                end
                default: rx_st_ff <= RX_IDLE;
            endcase
        end
    end

    // Receive holding register and flags; a new character beats the read clear
    always_ff @(posedge core_clk or negedge rst_i) begin
        if (!rst_i) begin
            rxbuf_ff <= 8'h00;
            rxrdy_ff <= 1'b0;
            ovr_ff   <= 1'b0;
            rxirq_ff <= 1'b0;
            txirq_ff <= 1'b0;
        end else if (ce) begin
            if (rx_done) rxbuf_ff <= align(rx_nsh, cfg_ff.len);
            rxrdy_ff <= rx_done || (rxrdy_ff && !rd_data);
            ovr_ff   <= (rx_done && rxrdy_ff && !rd_data) || (ovr_ff && !rd_ctrl);
            rxirq_ff <= rx_done || (rxrdy_ff && !rd_data);
            txirq_ff <= tb_in_rdy;
        end
    end

    assign io_rdata = rdata_ff;
    assign txd      = txd_ff;
    assign rx_irq   = rxirq_ff;
    assign tx_irq   = txirq_ff;

    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_i);

    property p_factor;
        ce && wr_baud && hi_sel_ff |=> factor_ff == {$past(io_req.data), $past(lo_ff)};
    endproperty
    a_factor: assert property (p_factor) else $error("factor not assembled");
    property p_addr;
        ce && io_req.wr && io_req.addr != ADDR_BAUD |=> $stable(factor_ff) && $stable(hi_sel_ff);
    endproperty
    a_addr: assert property (p_addr) else $error("factor written off its address");
    property p_baud;
        ce && baud_tick && factor_ff > 16'h0002 ##1 ce |=> !baud_tick;
    endproperty
    a_baud: assert property (p_baud) else $error("baud clock too fast");
    property p_break;
        ce && cfg_ff.brk |=> !txd_ff;
    endproperty
    a_break: assert property (p_break) else $error("break not driven");
    property p_false_start;
        ce && rx_st_ff == RX_START && rx_end && rxs_ff
            |=> rx_st_ff == RX_IDLE && $stable(rxbuf_ff);
    endproperty
    a_false_start: assert property (p_false_start) else $error("false start accepted");
    property p_sync_fill;
        ce && cfg_ff.sync && tx_st_ff == TX_IDLE && !tb_out_vld |=> tx_sh_ff == $past(sync_ff);
    endproperty
    a_sync_fill: assert property (p_sync_fill) else $error("sync char not inserted");
    property p_len;
        ce && rx_done |=> (rxbuf_ff >> ({2'h0, cfg_ff.len} + 4'h5)) == 8'h00;
    endproperty
    a_len: assert property (p_len) else $error("char length wrong");
    property p_rate;
        ce && !cfg_ff.sync && tx_st_ff == TX_DATA && baud_tick && tx_cnt_ff < os_len - 8'h01
            |=> tx_st_ff == TX_DATA && $stable(tx_idx_ff);
    endproperty
    a_rate: assert property (p_rate) else $error("async bit ended early");
    property p_rx_irq;
        ce && rx_done |=> rx_irq;
    endproperty
    a_rx_irq: assert property (p_rx_irq) else $error("receive interrupt missing");
    property p_tx_irq;
        ce && tb_in_rdy |=> tx_irq;
    endproperty
    a_tx_irq: assert property (p_tx_irq) else $error("transmit interrupt missing");

    c_rx_char: cover property (rx_done && !cfg_ff.sync);
    c_hunt_lock: cover property (rx_st_ff == RX_HUNT ##1 rx_st_ff == RX_DATA);
    c_buf_full: cover property (!tb_in_rdy);
    c_stop_15: cover property (tx_st_ff == TX_STOP && cfg_ff.stop == 2'h1 && tx_end);
endmodule
`default_nettype wire

// file: dv/serial_term.sv
/*
 Terminal model on the far end of the serial line: sends and catches async chars.
 Assumes bit periods in core clock cycles; its line moves at the falling edge.
*/
`timescale 1ns/10ps
`default_nettype none
module serial_term (
    input  wire logic clk, // Core clock
    input  wire logic txd, // Line from the port
    output logic      rxd  // Line to the port, idle mark
);
    initial rxd = 1'b1;

    // Start, bits LSB first, one stop; glitch > 0 sends a short false start only
    task automatic send_char(input logic [7:0] d, input int len, input int per,
                             input int glitch);
        if (glitch > 0) begin
            @(negedge clk) rxd = 1'b0;
            repeat (glitch) @(negedge clk);
            rxd = 1'b1;
        end else begin
            for (int i = -1; i <= len; i++) begin
                @(negedge clk) rxd = (i < 0) ? 1'b0 : (i == len) ? 1'b1 : d[i];
                repeat (per - 1) @(negedge clk);
            end
        end
    endtask

    // Catch one char at mid-bit; stp counts high cycles after the last bit
    task automatic take_char(input int len, input int per, output logic [7:0] d,
                             output int stp);
        int n;
        d = 8'h00;
        stp = 0;
        for (n = 0; txd !== 1'b0 && n < 4000; n++) @(negedge clk);
        repeat (per / 2) @(negedge clk);
        for (int i = 0; i < len; i++) begin
            repeat (per) @(negedge clk);
            d[i] = txd;
        end
        repeat (per / 2) @(negedge clk);
        for (stp = 0; txd === 1'b1 && stp < 300; stp++) @(negedge clk);
    endtask
endmodule
`default_nettype wire

// file: dv/tb_top.sv
/*
 Self-checking bench of the serial port: registers, framing, buffer, receive.
 Assumes the terminal model on the line and the 250 MHz core clock.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import serial_pkg::*;
    logic       core_clk, rst_n, ce, rxd, sync_in, txd, rx_irq, tx_irq, d64, ok, hit;
    io_req_t    io_req;
    logic [7:0] io_rdata, got, a, b;
    logic [47:0] sv;
    logic [7:0] q[$];
    int         miscompares, checks_done, cycles, stp, per, f, k, n, ln;

    serial_port i_serial_port (.core_clk(core_clk), .rst_n(rst_n), .ce(ce),
        .io_req(io_req), .io_rdata(io_rdata), .rxd(rxd), .sync_in(sync_in),
        .txd(txd), .rx_irq(rx_irq), .tx_irq(tx_irq));
    serial_term i_serial_term (.clk(core_clk), .txd(txd), .rxd(rxd));

    // Clock and hang guard
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            miscompares++;
            summarize();
        end
    end

    task automatic check(input logic [7:0] act, input logic [7:0] exp, input string what);
        checks_done++;
        if (act !== exp) begin
            miscompares++;
            $display("ERROR %0t %s got %h expected %h", $time, what, act, exp);
        end
    endtask
    task automatic summarize();
        $display("Checks %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Host I/O cycles, one strobe each
    task automatic io_wr(input logic [7:0] ad, input logic [7:0] d);
        @(negedge core_clk) io_req = '{1'b1, 1'b0, ad, d};
        @(negedge core_clk) io_req = '0;
    endtask
    task automatic io_rd(input logic [7:0] ad, output logic [7:0] d);
        @(negedge core_clk) io_req = '{1'b0, 1'b1, ad, 8'h00};
        @(negedge core_clk) d = io_rdata;
        io_req = '0;
    endtask
    task automatic set_factor(input logic [15:0] fv);
        io_wr(ADDR_BAUD, fv[7:0]);
        io_wr(ADDR_BAUD, fv[15:8]);
    endtask
    // Expectation helpers
    function automatic logic [7:0] ctrl_of(input int len, input int sb, input logic dv,
                                           input logic brk, input logic sy);
        cfg_t c;
        c = '{1'b0, brk, dv, 2'(sb), 2'(len - 5), sy};
        return c;
    endfunction
    function automatic logic [7:0] mask(input logic [7:0] d, input int len);
        return d & 8'((1 << len) - 1);
    endfunction
    function automatic int stop_cyc(input int sb, input int p);
        return (sb == 0) ? p : (sb == 1) ? p * 3 / 2 : p * 2;
    endfunction

    initial begin
        io_req = '0;
        ce = 1'b1;
        sync_in = 1'b0;
        rst_n = 1'b0;
        miscompares = 0;
        checks_done = 0;
        cycles = 0;
        void'($urandom(32'h0728));
        repeat (3) @(negedge core_clk);
        check({5'h00, txd, rx_irq, tx_irq}, 8'h04, "reset pins");
        check(io_rdata, 8'h00, "reset read data");
        rst_n = 1'b1;
        repeat (4) @(negedge core_clk);
        check({7'h00, tx_irq}, 8'h01, "room after reset");
        // Baud clock off: fill the buffer until it refuses
        for (k = 0; tx_irq === 1'b1 && k < 4; k++) begin
            q.push_back(8'($urandom));
            io_wr(ADDR_DATA, q[k]);
            @(negedge core_clk);
        end
        check(8'(k >= 2 && k <= 3), 8'h01, "buffer depth");
        io_rd(ADDR_CTRL, got);
        check({7'h00, got[ST_TXRDY]}, 8'h00, "status full");
        io_wr(ADDR_DATA, 8'hA5);
        f = $urandom_range(1, 3);
        per = 16 * f;
        set_factor(16'(f));
        io_wr(8'hDD, 8'h09);
        io_wr(8'hDD, 8'h00);
        for (int i = 0; i < k; i++) begin
            i_serial_term.take_char(5, per, got, stp);
            check(got, mask(q[i], 5), "drained char");
        end
        check(8'(stp == 300), 8'h01, "refused word not sent");
        check({7'h00, tx_irq}, 8'h01, "room after drain");
        // Every length and stop count, back to back pairs
        for (int len = 5; len <= 8; len++) begin
            for (int sb = 0; sb < 3; sb++) begin
                f = $urandom_range(1, 3);
                d64 = (len == 6 && sb == 1);
                per = (d64 ? 64 : 16) * f;
                set_factor(16'(f));
                io_wr(ADDR_CTRL, ctrl_of(len, sb, d64, 1'b0, 1'b0));
                a = 8'($urandom);
                b = (len == 8 && sb == 2) ? 8'hFF : 8'($urandom);
                io_wr(ADDR_DATA, a);
                io_wr(ADDR_DATA, b);
                i_serial_term.take_char(len, per, got, stp);
                check(got, mask(a, len), "tx char");
                ok = stp >= stop_cyc(sb, per) - 1 && stp <= stop_cyc(sb, per) + 1;
                check({7'h00, ok}, 8'h01, "stop length");
                i_serial_term.take_char(len, per, got, stp);
                check(got, mask(b, len), "second tx char");
            end
        end
        // Break holds the line low until cleared
        io_wr(ADDR_CTRL, ctrl_of(8, 0, 1'b0, 1'b1, 1'b0));
        repeat (8) @(negedge core_clk);
        check({7'h00, txd}, 8'h00, "break low");
        repeat (40) @(negedge core_clk);
        check({7'h00, txd}, 8'h00, "break held");
        io_wr(ADDR_CTRL, ctrl_of(8, 0, 1'b0, 1'b0, 1'b0));
        repeat (8) @(negedge core_clk);
        check({7'h00, txd}, 8'h01, "break released");
        // Receive, all lengths
        set_factor(16'h0002);
        per = 32;
        for (int i = 0; i < 4; i++) begin
            ln = 5 + i;
            io_wr(ADDR_CTRL, ctrl_of(ln, 0, 1'b0, 1'b0, 1'b0));
            a = (i == 0) ? 8'hFF : 8'($urandom);
            i_serial_term.send_char(a, ln, per, 0);
            for (n = 0; rx_irq !== 1'b1 && n < 200; n++) @(negedge core_clk);
            check({7'h00, rx_irq}, 8'h01, "rx waiting");
            io_rd(ADDR_CTRL, got);
            check({7'h00, got[ST_RXRDY]}, 8'h01, "status rx ready");
            io_rd(ADDR_DATA, got);
            check(got, mask(a, ln), "rx char");
            @(negedge core_clk);
            check({7'h00, rx_irq}, 8'h00, "rx cleared by read");
        end
        i_serial_term.send_char(8'h00, 8, per, per / 4);
        repeat (12 * per) @(negedge core_clk);
        check({7'h00, rx_irq}, 8'h00, "false start dropped");
        // Sync mode idles with repeated sync characters
        set_factor(16'h0004);
        // Random sync char, top bit clear so an idle line never matches it
        a = 8'($urandom) & 8'h7F;
        io_wr(ADDR_SYNC, a);
        io_wr(ADDR_CTRL, ctrl_of(8, 0, 1'b0, 1'b0, 1'b1));
        repeat (20) @(negedge core_clk);
        for (n = 0; txd === 1'b1 && n < 400; n++) @(negedge core_clk);
        @(negedge core_clk);
        for (int i = 0; i < 48; i++) begin
            sv[i] = txd;
            repeat (4) @(negedge core_clk);
        end
        ok = 1'b0;
        for (int r = 0; r < 8; r++) begin
            hit = 1'b1;
            for (int i = 0; i < 48; i++) hit &= (sv[i] === a[(i + r) % 8]);
            ok |= hit;
        end
        check({7'h00, ok}, 8'h01, "sync fill");
        // External sync locks the receiver; unread chars then overrun
        io_rd(ADDR_CTRL, got);
        check({7'h00, got[ST_LOCK]}, 8'h00, "no lock on idle line");
        io_wr(ADDR_CTRL, 8'h80 | ctrl_of(8, 0, 1'b0, 1'b0, 1'b1));
        @(negedge core_clk) sync_in = 1'b1;
        repeat (100) @(negedge core_clk);
        sync_in = 1'b0;
        io_rd(ADDR_CTRL, got);
        check({6'h00, got[ST_OVR], got[ST_LOCK]}, 8'h03, "ext sync lock, overrun");
        io_rd(8'h00, got);
        check(got, 8'h00, "unmapped read");
        summarize();
    end
endmodule
`default_nettype wire
